/* File: rtl/mtc_timer.v */
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "mtc_regs.vh"
// Contract
// - mode bit 3 starts counting, settable alone, self-clears the cycle after it is set, even with run bit 0
// - mode register is 8 bits, whole-byte write; start bit also alone
// - reset clears the mode register
// - write-only output enable gates toggle flop onto output pin
// - each match without a start in the same cycle inverts the toggle flop
// - setting the start bit clears the toggle flop
// - reset clears output enable and toggle flop
// - run bit 0 blocks count pulses, counter holds
// - run bit 1 feeds pulse chosen by bits 4 to 6
// - pin, modulo write, count read, flag access work in any mode
// - modulo register loads as one 8-bit write
// - external source selected: pin output is input divided by 2(N+1)
// - generated clock goes to serial interface as shift clock
// - count equals modulo when a count pulse arrives: match, invert flop, clear count
// - match interval is (modulo plus one) count pulse periods
module mtc_timer (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [13:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        external_event_input,
  output wire        toggle_output_pin,
  output wire        toggle_output_pin_oe,
  output wire        shift_clock,
  output wire        irq
);
  reg  [7:0]             counter_mode_control_r;
  reg                    toggle_output_enable_r;
  reg                    toggle_flip_flop_r;
  reg  [7:0]             modulo_value_reg_r;
  reg  [7:0]             count_value_reg_r;
  reg  [`MTC_ST_W-1:0]   status_r;
  reg  [`MTC_ST_W-1:0]   ien_r;
  reg  [`MTC_PRE_W-1:0]  pre_r;
  reg  [`MTC_PRE_W-1:0]  pre_nxt;
  reg                    count_pulse;
  reg                    hit;
  reg  [11:0]            idx;
  wire                   ext_rise;
  wire [`MTC_PRE_W-1:0]  pre_rise;
  wire                   wr;
  wire                   rd;
  wire                   addr_ok;
  wire                   start_req;
  wire                   match;
  wire [2:0]             sel;

  // byte address is four times the register index
  always @* begin
    idx = paddr[13:2];
  end
  assign wr      = psel & penable & pwrite;
  assign rd      = psel & ~pwrite;
  assign pready  = 1'b1; // zero-wait slave
  assign pslverr = psel & penable & ~addr_ok;
  assign addr_ok = (idx == `MTC_IDX_TOE) | (idx == `MTC_IDX_MODE) | (idx == `MTC_IDX_MODULO) |
                   (idx == `MTC_IDX_COUNT) | (idx == `MTC_IDX_STATUS) |
                   (idx == `MTC_IDX_CLEAR) | (idx == `MTC_IDX_IEN) | (idx == `MTC_IDX_START);

  // the start bit is written either through the mode byte or its own alias
  assign start_req = wr & (((idx == `MTC_IDX_MODE) & pwdata[`MTC_MODE_START]) |
                           ((idx == `MTC_IDX_START) & pwdata[0]));
  assign sel = counter_mode_control_r[`MTC_MODE_SEL_HI:`MTC_MODE_SEL_LO];

  // free prescaler; taps give slower count pulses as one-cycle enables
  always @* begin
    pre_nxt = pre_r + {{(`MTC_PRE_W-1){1'b0}}, 1'b1};
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) pre_r <= {`MTC_PRE_W{1'b0}};
    else pre_r <= pre_nxt;
  end

  // one rising-edge detector per prescaler bit
  genvar gi;
  generate
    for (gi = 0; gi < `MTC_PRE_W; gi = gi + 1) begin : g_tap
      mtc_edge_detect u_tap (
        .pclk    (pclk),
        .presetn (presetn),
        .sig     (pre_r[gi]),
        .rise    (pre_rise[gi])
      );
    end
  endgenerate

  // external event edges are counted, so the pin divides by 2(N+1)
  mtc_edge_detect u_ext (
    .pclk    (pclk),
    .presetn (presetn),
    .sig     (external_event_input),
    .rise    (ext_rise)
  );

  // count pulse mux; unlisted codes give no pulse
  always @* begin
    case (sel)
      `MTC_SEL_EXT:  count_pulse = ext_rise;
      `MTC_SEL_DIV0: count_pulse = pre_rise[`MTC_TAP0];
      `MTC_SEL_DIV1: count_pulse = pre_rise[`MTC_TAP1];
      `MTC_SEL_DIV2: count_pulse = pre_rise[`MTC_TAP2];
      `MTC_SEL_DIV3: count_pulse = pre_rise[`MTC_TAP3];
      default:       count_pulse = 1'b0;
    endcase
    hit = count_pulse & counter_mode_control_r[`MTC_MODE_RUN];
  end

  // match when the counter equals modulo and another pulse arrives: period is N+1
  assign match = hit & (count_value_reg_r == modulo_value_reg_r);

  // mode register; start bit self-clears one cycle after it is set
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_mode_control_r <= `MTC_MODE_RST;
    end else if (wr & (idx == `MTC_IDX_MODE)) begin
      counter_mode_control_r <= pwdata[7:0];
    end else if (wr & (idx == `MTC_IDX_START) & pwdata[0]) begin
      counter_mode_control_r[`MTC_MODE_START] <= 1'b1;
    end else if (counter_mode_control_r[`MTC_MODE_START]) begin
      counter_mode_control_r[`MTC_MODE_START] <= 1'b0;
    end
  end

  // output enable and modulo, each a single whole write; modulo works in any mode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      toggle_output_enable_r <= 1'b0;
      modulo_value_reg_r     <= `MTC_BYTE_ZERO;
    end else begin
      if (wr & (idx == `MTC_IDX_TOE))
        toggle_output_enable_r <= pwdata[0];
      if (wr & (idx == `MTC_IDX_MODULO))
        modulo_value_reg_r <= pwdata[7:0];
    end
  end

  // counter and toggle flop; a start restarts both from zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value_reg_r  <= `MTC_BYTE_ZERO;
      toggle_flip_flop_r <= 1'b0;
    end else if (start_req) begin
      count_value_reg_r  <= `MTC_BYTE_ZERO;
      toggle_flip_flop_r <= 1'b0;
    end else if (match) begin
      count_value_reg_r  <= `MTC_BYTE_ZERO;
      toggle_flip_flop_r <= ~toggle_flip_flop_r;
    end else if (hit) begin
      count_value_reg_r  <= count_value_reg_r + 8'h01;
    end
  end

  // sticky status; a set in the same cycle as a clear wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= {`MTC_ST_W{1'b0}};
      ien_r    <= {`MTC_ST_W{1'b0}};
    end else begin
      if (wr & (idx == `MTC_IDX_IEN))
        ien_r <= pwdata[`MTC_ST_W-1:0];
      status_r[`MTC_ST_MATCH] <= match |
        (status_r[`MTC_ST_MATCH] &
         ~(wr & (idx == `MTC_IDX_CLEAR) & pwdata[`MTC_ST_MATCH]));
      status_r[`MTC_ST_START] <= start_req |
        (status_r[`MTC_ST_START] &
         ~(wr & (idx == `MTC_IDX_CLEAR) & pwdata[`MTC_ST_START]));
    end
  end

  assign irq = |(status_r & ien_r);

  // pin drives the flop when enabled, in any mode
  assign toggle_output_pin    = toggle_output_enable_r & toggle_flip_flop_r;
  assign toggle_output_pin_oe = toggle_output_enable_r;
  assign shift_clock          = toggle_flip_flop_r;

  // read data registered in setup phase; reading the count never touches it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd & ~penable) begin
      case (idx)
        `MTC_IDX_MODE:   prdata <= {24'h00_0000, counter_mode_control_r};
        `MTC_IDX_MODULO: prdata <= {24'h00_0000, modulo_value_reg_r};
        `MTC_IDX_COUNT:  prdata <= {24'h00_0000, count_value_reg_r};
        `MTC_IDX_STATUS: prdata <= {30'h0000_0000, status_r};
        `MTC_IDX_IEN:    prdata <= {30'h0000_0000, ien_r};
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule // mtc_timer
`default_nettype wire

/* File: rtl/mtc_regs.vh */
`ifndef MTC_REGS_VH
`define MTC_REGS_VH
// register indices; the byte address on the bus is four times the index
`define MTC_IDX_TOE      12'h0fa2
`define MTC_IDX_MODE     12'h0fa0
`define MTC_IDX_MODULO   12'h0fa4
`define MTC_IDX_COUNT    12'h0fa5
`define MTC_IDX_STATUS   12'h0fa6
`define MTC_IDX_CLEAR    12'h0fa7
`define MTC_IDX_IEN      12'h0fa8
`define MTC_IDX_START    12'h0fa9
// mode register fields
`define MTC_MODE_RUN     2
`define MTC_MODE_START   3
`define MTC_MODE_SEL_LO  4
`define MTC_MODE_SEL_HI  6
// select codes
`define MTC_SEL_EXT      3'h0
`define MTC_SEL_DIV0     3'h4
`define MTC_SEL_DIV1     3'h5
`define MTC_SEL_DIV2     3'h6
`define MTC_SEL_DIV3     3'h7
// prescaler taps (bit of a free counter)
`define MTC_TAP0         9
`define MTC_TAP1         7
`define MTC_TAP2         5
`define MTC_TAP3         3
`define MTC_PRE_W        10
// reset values
`define MTC_MODE_RST     8'h00
`define MTC_BYTE_ZERO    8'h00
// status bits
`define MTC_ST_MATCH     0
`define MTC_ST_START     1
`define MTC_ST_W         2
`endif

/* File: rtl/mtc_edge_detect.v */
`timescale 1ns/1ns
`default_nettype none
// rising edge detector with registered history; input is already synchronous
module mtc_edge_detect (
  input  wire pclk,
  input  wire presetn,
  input  wire sig,
  output wire rise
);
  reg sig_r;
  // history flop for the edge compare
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) sig_r <= 1'b0;
    else sig_r <= sig;
  end
  assign rise = sig & ~sig_r;
endmodule // mtc_edge_detect
`default_nettype wire

/* File: verification/mtc_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
`include "mtc_regs.vh"
module mtc_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        external_event_input,
  input wire logic        toggle_output_pin,
  input wire logic        toggle_output_pin_oe,
  input wire logic        shift_clock,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // decoded access phases; a write lands at the access edge only
  wire acc  = psel & penable;
  wire wtoe = acc & pwrite & (paddr == {`MTC_IDX_TOE, 2'b00});
  // a start comes through the mode byte or through its one-bit alias
  wire wst  = acc & pwrite &
              (((paddr == {`MTC_IDX_MODE, 2'b00}) & pwdata[`MTC_MODE_START]) |
               ((paddr == {`MTC_IDX_START, 2'b00}) & pwdata[0]));
  wire wd0  = pwdata[0];
  a_pin_gated: assert property (toggle_output_pin == (shift_clock & toggle_output_pin_oe))
    else $error("pin not gated by enable");
  a_oe_write: assert property (wtoe |=> toggle_output_pin_oe == $past(wd0))
    else $error("enable flag missed its write");
  a_oe_hold: assert property ($changed(toggle_output_pin_oe) |-> $past(wtoe))
    else $error("enable flag moved without a write");
  a_start_clear: assert property (wst |=> !shift_clock)
    else $error("start left flop set");
  a_reset_quiet: assert property ($rose(presetn) |-> !toggle_output_pin_oe && !shift_clock)
    else $error("flop or enable not cleared by reset");
  a_ready_high: assert property (psel |-> pready)
    else $error("wait state inserted");
  a_err_phase: assert property (pslverr |-> acc)
    else $error("error outside access phase");
  a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_mode_mapped: assert property (acc && paddr == {`MTC_IDX_MODE, 2'b00} |-> !pslverr)
    else $error("mode access refused");
  c_start: cover property (wst);
  c_enable: cover property (wtoe && wd0);
  c_irq: cover property (irq);
endmodule // mtc_asserts
bind mtc_timer mtc_asserts chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .external_event_input, .toggle_output_pin,
  .toggle_output_pin_oe, .shift_clock, .irq);
`default_nettype wire

/* File: verification/mtc_ev_src.sv */
`timescale 1ns/1ns
`default_nettype none
module mtc_ev_src (
  input  wire logic       clk,
  input  wire logic [7:0] per,
  output logic            ev = 1'b0
);
  logic [7:0] c = 8'h00;
  // one-cycle pulse every per cycles; zero keeps the line quiet
  always @(posedge clk) begin
    c <= (c + 1 >= per) ? 8'h00 : c + 8'h01;
    ev <= (per != 8'h00) && (c == 8'h00);
  end
endmodule // mtc_ev_src
`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "mtc_regs.vh"
module testbench;
  logic        pclk = 0;
  logic        presetn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [13:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [7:0]  per = 0;
  logic [7:0]  m;
  wire  [31:0] prdata;
  wire         pready, pslverr, ev, pin, oe, sck, irq;
  logic [32:0] expq[$];
  int          seed = 32'h35bd;
  int          errors = 0;
  int          n_tests = 0;
  always #5 pclk = ~pclk;
  mtc_ev_src src_u (.clk(pclk), .per, .ev);
  mtc_timer dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .external_event_input(ev), .toggle_output_pin(pin),
    .toggle_output_pin_oe(oe), .shift_clock(sck), .irq);
  task finish_test();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // automatic: the read monitor and the main sequence may both call it
  task automatic chk(string n, logic [32:0] e, logic [32:0] g);
    n_tests++;
    if (g !== e) errors++;
    if (g !== e) $display("[FAIL] %s exp %h got %h", n, e, g);
  endtask
  // request held until pready is seen high at an access edge
  task xfer(logic w, logic [11:0] i, logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, i, 2'b00, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask
  task rd(logic [11:0] i, logic [31:0] e, logic s = 0);
    expq.push_back({s, e});
    xfer(0, i, 0);
  endtask
  // cycles between two flop edges, bounded so a dead flop cannot hang here
  task meas(int e);
    logic s;
    int c;
    @(posedge pclk) s = sck;
    c = 0;
    while (sck === s && c < 5000) @(posedge pclk) c++;
    s = sck;
    c = 0;
    while (sck === s && c < 5000) @(posedge pclk) c++;
    chk("period", 33'(e), 33'(c));
  endtask
  // reads are judged in their access cycle against the oldest note
  always @(posedge pclk)
    if (psel & penable & !pwrite) chk("read", expq.pop_front(), {pslverr, prdata});
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    rd(`MTC_IDX_MODE, 0);
    chk("outputs", 0, {oe, sck, irq});
    rd(`MTC_IDX_TOE, 0);
    rd(12'h0123, 0, 1);
    $display("reset test done");
    xfer(1, `MTC_IDX_MODULO, 1);
    for (int s = 4; s < 8; s++) begin
      xfer(1, `MTC_IDX_MODE, {s[2:0], 4'hc});
      meas(2 * (16 << (2 * (7 - s))));
    end
    $display("prescaler test done");
    m = (8'($random(seed)) & 8'h0f) | 8'h01;
    xfer(1, `MTC_IDX_MODULO, m);
    rd(`MTC_IDX_MODULO, m);
    xfer(1, `MTC_IDX_MODE, 8'h7c);
    rd(`MTC_IDX_MODE, 8'h74);
    xfer(1, `MTC_IDX_TOE, 1);
    meas((m + 1) * 16);
    chk("pin", sck, pin);
    xfer(1, `MTC_IDX_START, 1);
    rd(`MTC_IDX_MODE, 8'h74);
    xfer(1, `MTC_IDX_MODE, 8'h78);
    repeat (2) @(posedge pclk);
    chk("flop", 0, sck);
    rd(`MTC_IDX_COUNT, 0);
    repeat (50) @(posedge pclk);
    rd(`MTC_IDX_COUNT, 0);
    rd(`MTC_IDX_STATUS, 3);
    chk("masked", 0, irq);
    xfer(1, `MTC_IDX_IEN, 3);
    repeat (2) @(posedge pclk);
    chk("irq", 1, irq);
    xfer(1, `MTC_IDX_CLEAR, 3);
    repeat (2) @(posedge pclk);
    chk("irq", 0, irq);
    rd(`MTC_IDX_STATUS, 0);
    $display("status test done");
    per <= (8'($random(seed)) & 8'h07) | 8'h02;
    xfer(1, `MTC_IDX_MODE, 8'h0c);
    meas((m + 1) * per);
    $display("event test done");
    finish_test();
  end
  // hang guard, far beyond the slowest prescaler period
  initial begin
    #500_000;
    errors++;
    finish_test();
  end
endmodule // testbench
`default_nettype wire
